// [rtl/awp_pkg.sv]
// Overview of operation
// - The bridge answers as an AHB slave and forwards each accepted transfer, except writes to a protected slot, to APB peripheral registers.
// - APB side honours peripheral wait states, returns slave errors to the AHB master, and carries protection.
// - Byte, half-word and word strobes are produced for reads as well as writes.
// - APB address and data phases are merged into one cycle, with select and enable rising together.
// - Writing one to a clear-register bit unprotects that peripheral; a read shows 1 while protected.
// - Zero bits written to either protection register leave the protection state unchanged.
// - Trace buffer is bit 6, I/O port bit 3, flash controller bit 2, service unit bit 1; only bit 1 is set at reset.
// - The set register sits at 0x04 with the same bits, reset value and read-back state as the clear register.
package awp_pkg;

  // register byte offsets
  localparam logic [3:0]  OFS_PROT_CLEAR = 4'h0;
  localparam logic [3:0]  OFS_PROT_SET   = 4'h4;

  // protection bit positions
  localparam int          BIT_SERVICE_UNIT_GUARD  = 1;
  localparam int          BIT_FLASH_CTRL_GUARD    = 2;
  localparam int          BIT_IO_PORT_GUARD       = 3;
  localparam int          BIT_TRACE_BUFFER_GUARD  = 6;

  // reset value and implemented bits
  localparam logic [31:0] PROT_RESET = 32'h0000_0002;
  localparam logic [31:0] PROT_MASK  = 32'h0000_004e;

  // peripheral slot decode within the bridge window
  localparam int          SLOT_LSB   = 10;

  // ahb encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_BYTE    = 3'h0;
  localparam logic [2:0]  HSIZE_HALF    = 3'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DATA,
    ST_ACCESS,
    ST_ERR1,
    ST_ERR2
  } awp_state_e;

endpackage

// [rtl/awp_strobe.sv]
`timescale 1ns/1ps
module awp_strobe (
  input  wire logic [2:0] size,
  input  wire logic [1:0] addr_lo,
  output logic      [3:0] strb
);

  // sparse lane select, same for reads and writes
  always_comb begin
    if (size == awp_pkg::HSIZE_BYTE) begin
      strb = 4'h1 << addr_lo;
    end else if (size == awp_pkg::HSIZE_HALF) begin
      strb = addr_lo[1] ? 4'hc : 4'h3;
    end else begin
      strb = 4'hf;
    end
  end

endmodule

// [rtl/awp_bridge.sv]
`timescale 1ns/1ps
module awp_bridge #(
  parameter int SLOT_W = 5
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [3:0]  hprot,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // apb4 master
  output logic      [31:0] paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  output logic      [2:0]  pprot,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // avalon-mm register slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);

  ////////////////////////////////////////////////////////////////////////////
  // register slave

  logic [31:0] prot_q, prot_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wait_q, wait_d;
  logic        reg_ack;
  logic [31:0] wmask;

  assign reg_ack = (avs_read | avs_write) & ~wait_q;
  assign wmask   = avs_writedata & {{24{1'b0}}, {8{avs_byteenable[0]}}} & awp_pkg::PROT_MASK;

  // one wait cycle, then answer for a single edge
  always_comb begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    prot_d  = prot_q;
    if ((avs_read | avs_write) & wait_q) begin
      wait_d  = 1'b0;
      rdata_d = 32'h0000_0000;
      if (avs_address == awp_pkg::OFS_PROT_CLEAR || avs_address == awp_pkg::OFS_PROT_SET) begin
        rdata_d = prot_q & awp_pkg::PROT_MASK;
      end
    end
    if (avs_write & ~wait_q) begin
      if (avs_address == awp_pkg::OFS_PROT_CLEAR) begin
        prot_d = prot_q & ~wmask;
      end else if (avs_address == awp_pkg::OFS_PROT_SET) begin
        prot_d = prot_q | wmask;
      end
    end
  end

  // register state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prot_q  <= awp_pkg::PROT_RESET;
      rdata_q <= 32'h0000_0000;
      wait_q  <= 1'b1;
    end else begin
      prot_q  <= prot_d;
      rdata_q <= rdata_d;
      wait_q  <= wait_d;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // ahb to apb transfer engine

  awp_pkg::awp_state_e state_q, state_d;
  logic [31:0] addr_q, addr_d;
  logic        wr_q, wr_d;
  logic [3:0]  strb_q, strb_d;
  logic [2:0]  pprot_q, pprot_d;
  logic        psel_q, psel_d;
  logic [31:0] pwdata_q, pwdata_d;
  logic        hready_q, hready_d;
  logic        hresp_q, hresp_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [3:0]  lane_strb;
  logic        accept;
  logic        blocked;

  awp_strobe awp_strobe_i (
    .size    (hsize),
    .addr_lo (haddr[1:0]),
    .strb    (lane_strb)
  );

  assign accept  = hsel & (htrans == awp_pkg::HTRANS_NONSEQ || htrans == 2'h3) & hready & hready_q;
  assign blocked = wr_q & prot_q[addr_q[awp_pkg::SLOT_LSB +: SLOT_W]];

  // next state of the transfer engine
  always_comb begin
    state_d  = state_q;
    addr_d   = addr_q;
    wr_d     = wr_q;
    strb_d   = strb_q;
    pprot_d  = pprot_q;
    psel_d   = psel_q;
    pwdata_d = pwdata_q;
    hready_d = hready_q;
    hresp_d  = hresp_q;
    hrdata_d = hrdata_q;
    case (state_q)
      awp_pkg::ST_IDLE, awp_pkg::ST_ERR2: begin
        hready_d = 1'b1;
        hresp_d  = 1'b0;
        state_d  = awp_pkg::ST_IDLE;
        if (accept) begin
          addr_d   = haddr;
          wr_d     = hwrite;
          strb_d   = lane_strb;
          pprot_d  = {~hprot[0], 1'b0, hprot[1]};
          hready_d = 1'b0;
          state_d  = awp_pkg::ST_DATA;
        end
      end
      awp_pkg::ST_DATA: begin
        if (blocked) begin
          hresp_d = 1'b1;
          state_d = awp_pkg::ST_ERR1;
        end else begin
          psel_d   = 1'b1;
          pwdata_d = wr_q ? hwdata : 32'h0000_0000;
          state_d  = awp_pkg::ST_ACCESS;
        end
      end
      awp_pkg::ST_ACCESS: begin
        if (pready) begin
          psel_d   = 1'b0;
          hrdata_d = (wr_q | pslverr) ? 32'h0000_0000 : prdata;
          if (pslverr) begin
            hresp_d = 1'b1;
            state_d = awp_pkg::ST_ERR1;
          end else begin
            hready_d = 1'b1;
            state_d  = awp_pkg::ST_IDLE;
          end
        end
      end
      awp_pkg::ST_ERR1: begin
        hready_d = 1'b1;
        state_d  = awp_pkg::ST_ERR2;
      end
      default: begin
        state_d  = awp_pkg::ST_IDLE;
        psel_d   = 1'b0;
        hready_d = 1'b1;
        hresp_d  = 1'b0;
      end
    endcase
  end

  // transfer engine registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q  <= awp_pkg::ST_IDLE;
      addr_q   <= 32'h0000_0000;
      wr_q     <= 1'b0;
      strb_q   <= 4'h0;
      pprot_q  <= 3'h0;
      psel_q   <= 1'b0;
      pwdata_q <= 32'h0000_0000;
      hready_q <= 1'b1;
      hresp_q  <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      state_q  <= state_d;
      addr_q   <= addr_d;
      wr_q     <= wr_d;
      strb_q   <= strb_d;
      pprot_q  <= pprot_d;
      psel_q   <= psel_d;
      pwdata_q <= pwdata_d;
      hready_q <= hready_d;
      hresp_q  <= hresp_d;
      hrdata_q <= hrdata_d;
    end
  end

  // outputs straight from flops
  assign hreadyout = hready_q;
  assign hresp     = hresp_q;
  assign hrdata    = hrdata_q;
  assign paddr     = addr_q;
  assign psel      = psel_q;
  assign penable   = psel_q;
  assign pwrite    = wr_q;
  assign pwdata    = pwdata_q;
  assign pstrb     = strb_q;
  assign pprot     = pprot_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence err_two_cycle;
    (hresp && !hreadyout) ##1 (hresp && hreadyout);
  endsequence

  sequence blocked_seen;
    state_q == awp_pkg::ST_DATA && blocked;
  endsequence

  chk_forward_apb: assert property ((state_q == awp_pkg::ST_DATA && !blocked) |=> psel && (paddr == $past(addr_q)))
    else $error("accepted transfer not forwarded");
  chk_apb_wait: assert property ((psel && !pready) |=> psel && !hreadyout)
    else $error("apb wait state dropped");
  chk_slverr_resp: assert property ((psel && pready && pslverr) |=> err_two_cycle)
    else $error("slave error not reported");
  chk_read_strobe: assert property ((psel && !pwrite) |-> pstrb != 4'h0)
    else $error("read without strobes");
  chk_merged_phase: assert property (psel == penable)
    else $error("setup phase seen on apb");
  chk_clear_bit: assert property ((avs_write && !avs_waitrequest && avs_address == awp_pkg::OFS_PROT_CLEAR
      && avs_byteenable[0] && avs_writedata[awp_pkg::BIT_SERVICE_UNIT_GUARD])
      |=> !prot_q[awp_pkg::BIT_SERVICE_UNIT_GUARD])
    else $error("clear write left protection on");
  chk_zero_keeps: assert property ((avs_write && !avs_waitrequest && avs_writedata[7:0] == 8'h00)
      |=> $stable(prot_q))
    else $error("zero write changed protection");
  chk_reset_value: assert property ($rose(rst_n) |-> prot_q == awp_pkg::PROT_RESET)
    else $error("wrong protection reset value");
  chk_readback: assert property ((avs_read && !avs_waitrequest && (avs_address == awp_pkg::OFS_PROT_SET
      || avs_address == awp_pkg::OFS_PROT_CLEAR)) |-> avs_readdata == prot_q)
    else $error("readback differs from state");
  chk_set_bit: assert property ((avs_write && !avs_waitrequest && avs_address == awp_pkg::OFS_PROT_SET
      && avs_byteenable[0] && avs_writedata[awp_pkg::BIT_TRACE_BUFFER_GUARD])
      |=> prot_q[awp_pkg::BIT_TRACE_BUFFER_GUARD])
    else $error("set write left protection off");
  chk_blocked_write: assert property (blocked_seen |=> !psel ##0 err_two_cycle)
    else $error("protected write not blocked");

endmodule

// [sim/awp_apb_periph.sv]
`timescale 1ns/1ps
// apb peripheral model: one word per slot, programmable stalls and error answer
module awp_apb_periph (
  input  wire logic        clk,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic [1:0]  wait_cnt,
  input  wire logic        fail_en,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  logic [31:0] mem [32];
  logic [31:0] last_q;
  logic [1:0]  cnt_q;
  logic [4:0]  idx;

  ////////////////////////////////////////////////////////////
  // answer after wait_cnt stalls; idle data bus keeps toggling
  assign idx     = paddr[14:10];
  assign pready  = psel && penable && cnt_q == wait_cnt;
  assign pslverr = pready && fail_en;
  assign prdata  = pready ? mem[idx] : ~last_q;

  // stall counter and byte-lane writes
  always_ff @(posedge clk) begin
    cnt_q  <= (psel && !pready) ? cnt_q + 2'h1 : 2'h0;
    last_q <= prdata;
    for (int b = 0; b < 4; b++) begin
      if (pready && pwrite && pstrb[b]) begin
        mem[idx][8*b +: 8] <= pwdata[8*b +: 8];
      end
    end
  end
endmodule

// [sim/apb_bridge_write_protect_test.sv]
`timescale 1ns/1ps
module apb_bridge_write_protect_test;
  logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, psel, penable, pwrite, pready, pslverr;
  logic        avs_read, avs_write, avs_waitrequest, fail_en, resp;
  logic [1:0]  htrans, wait_cnt, tr_kind;
  logic [2:0]  hsize, pprot, prot_seen;
  logic [3:0]  hprot, pstrb, avs_address, avs_byteenable, strb_seen;
  logic [31:0] haddr, hwdata, hrdata, paddr, pwdata, prdata, avs_writedata, avs_readdata, rd;
  int          bad_count, comparisons, apb_cnt, cyc, n;

  // bridge under test
  awp_bridge awp_bridge_i (
    .clk             (clk),
    .rst_n           (rst_n),
    .hsel            (hsel),
    .haddr           (haddr),
    .htrans          (htrans),
    .hwrite          (hwrite),
    .hsize           (hsize),
    .hprot           (hprot),
    .hwdata          (hwdata),
    .hready          (hready),
    .hreadyout       (hreadyout),
    .hresp           (hresp),
    .hrdata          (hrdata),
    .paddr           (paddr),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .pwdata          (pwdata),
    .pstrb           (pstrb),
    .pprot           (pprot),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest)
  );

  // peripheral model on the far side
  awp_apb_periph awp_apb_periph_i (
    .clk      (clk),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .pstrb    (pstrb),
    .wait_cnt (wait_cnt),
    .fail_en  (fail_en),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr)
  );
  assign hready = hreadyout;

  ////////////////////////////////////////////////////////////
  // clock runs before any transfer
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // apb monitor and run-time limit
  always @(posedge clk) begin
    cyc++;
    if (psel === 1'b1) chk({31'h0, penable}, 32'h1);
    if (psel === 1'b1 && pready === 1'b1) begin
      apb_cnt++;
      strb_seen <= pstrb;
      prot_seen <= pprot;
    end
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // avalon request held until waitrequest is seen low
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask

  // register write, then read back offset ra
  task automatic prot_step(input logic [3:0] wa, input logic [31:0] wd, input logic [3:0] ra, input logic [31:0] e);
    av_xfer(1'b1, wa, wd, rd);
    av_xfer(1'b0, ra, 32'h0, rd);
    chk(rd, e);
  endtask

  // single ahb transfer; n counts edges from acceptance to completion
  task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] d);
    n = 0;
    hsel   <= 1'b1;
    htrans <= tr_kind;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= sz;
    @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1);
    rd   = hrdata;
    resp = hresp;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    prot_step(4'h8, 32'h0, 4'h0, 32'h0000_0002);
    prot_step(4'h8, 32'h0, 4'h4, 32'h0000_0002);
    prot_step(4'h4, 32'hffff_ffff, 4'h0, 32'h0000_004e);
    prot_step(4'h0, 32'h0, 4'h4, 32'h0000_004e);
    prot_step(4'h0, 32'h0000_0048, 4'h0, 32'h0000_0006);
    prot_step(4'h8, 32'hffff_ffff, 4'h4, 32'h0000_0006);
    prot_step(4'h4, 32'h0, 4'h0, 32'h0000_0006);
    prot_step(4'h0, 32'h0000_0006, 4'h4, 32'h0);
    avs_byteenable <= 4'he;
    prot_step(4'h4, 32'h0000_00ff, 4'h0, 32'h0);
    avs_byteenable <= 4'hf;
  endtask

  task automatic t_bridge();
    ahb_xfer(1'b1, 32'h0000_0c00, 3'h2, 32'h1122_3344);
    chk({31'h0, resp}, 32'h0);
    chk(n, 32'd3);
    chk({29'h0, prot_seen}, 32'h1);
    ahb_xfer(1'b1, 32'h0000_0c01, awp_pkg::HSIZE_BYTE, 32'h0000_aa00);
    chk({28'h0, strb_seen}, 32'h2);
    wait_cnt <= 2'h2;
    hprot    <= 4'h0;
    ahb_xfer(1'b0, 32'h0000_0c02, awp_pkg::HSIZE_HALF, 32'h0);
    chk({28'h0, strb_seen}, 32'hc);
    chk({29'h0, prot_seen}, 32'h4);
    chk(n, 32'd5);
    chk(rd, 32'h1122_aa44);
    wait_cnt <= 2'h0;
    hprot    <= 4'h3;
  endtask

  task automatic t_blocked();
    int c;
    av_xfer(1'b1, 4'h4, 32'h0000_0008, rd);
    c = apb_cnt;
    ahb_xfer(1'b1, 32'h0000_0c00, 3'h2, 32'hdead_beef);
    chk({31'h0, resp}, 32'h1);
    chk(apb_cnt, c);
    ahb_xfer(1'b0, 32'h0000_0c00, 3'h2, 32'h0);
    chk(rd, 32'h1122_aa44);
    fail_en <= 1'b1;
    tr_kind = 2'h3;
    ahb_xfer(1'b0, 32'h0000_1400, 3'h2, 32'h0);
    chk({31'h0, resp}, 32'h1);
    fail_en <= 1'b0;
    tr_kind = awp_pkg::HTRANS_NONSEQ;
  endtask

  // reset, then scenarios in order
  initial begin
    {rst_n, hsel, hwrite, avs_read, avs_write, fail_en} = 6'h0;
    {htrans, wait_cnt, hsize, haddr, hwdata} = '0;
    tr_kind = awp_pkg::HTRANS_NONSEQ;
    {avs_address, avs_writedata} = '0;
    hprot = 4'h3;
    avs_byteenable = 4'hf;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_bridge();
    t_blocked();
    test_done();
  end
endmodule
